/* hw/mmd_pkg.sv */
// Constants, codes and state type for the indirect extended register access block.
package mmd_pkg;
    // Direct register offsets of the access control and window registers.
    localparam logic [4:0] REG_CTRL = 5'h0D;
    localparam logic [4:0] REG_WIN = 5'h0E;
    // The only managed device select value that the block answers to.
    localparam logic [4:0] DEVSEL_GENERAL = 5'h1F;
    // Window function codes held in the top two control bits.
    localparam logic [1:0] FN_ADDR = 2'h0;
    localparam logic [1:0] FN_DATA = 2'h1;
    localparam logic [1:0] FN_INC_RW = 2'h2;
    localparam logic [1:0] FN_INC_WR = 2'h3;
    // Management frame opcodes.
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_READ = 2'h2;
    // Extended clock output control register and its value after reset.
    localparam logic [15:0] CLK_CTRL_ADDR = 16'h0170;
    localparam logic [15:0] CLK_CTRL_RESET = 16'h0C10;
    localparam int CLK_OFF_BIT = 6;
    // Extended addresses below this, except the control and window offsets, fold onto the direct registers.
    localparam logic [15:0] DIRECT_SPAN = 16'h0020;
    localparam logic [15:0] REG_RESET = 16'h0000;
    localparam logic [4:0] PHY_ADDR_RESET = 5'h00;
    // Clock edges after reset release at which the strap is sampled; the last one wins.
    localparam logic [1:0] STRAP_LAST = 2'h3;
    // Bit counts of frame fields, as last index of a five bit counter.
    localparam logic [4:0] HDR_LAST = 5'h0B;
    localparam logic [4:0] DATA_LAST = 5'h0F;
    localparam logic [4:0] SKIP_LAST = 5'h11;
    // Frame receiver states.
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_START = 3'b001,
        ST_HDR = 3'b010,
        ST_TA = 3'b011,
        ST_DATA = 3'b100,
        ST_SKIP = 3'b101
    } frame_st_t;
endpackage

/* hw/mmd_indirect_register_access.sv */
// Management frame slave with direct registers and indirect extended register window.
`timescale 1ns/1ps

// What this block does
// [RQ1] Decode frame register field, 32 words read/write.
// [RQ2] Indirect access never reaches control or window.
// [RQ3] Control bits 4:0 hold managed device select.
// [RQ4] Only all-ones select value is implemented.
// [RQ5] Window accesses with wrong select are ignored.
// [RQ6] Control bits 15:14 choose the window function.
// [RQ7] Function 00 window reaches the address register.
// [RQ8] Function 01 data access, address unchanged.
// [RQ9] Function 10 increments address after any access.
// [RQ10] Function 11 increments address after writes only.
// [RQ11] Controller loads address before extended data accesses.
// [RQ12] Controller sequence for non-incrementing access.
// [RQ13] Address register holds its value between frames.
// [RQ14] Controller selects increment functions for bursts.
// [RQ15] Repeated address-function writes keep overwriting address.
// [RQ16] Repeated non-incrementing reads return same register.
// [RQ17] Extended clock control register resets to 0C10.
// [RQ18] Writing 0C50 there disables the clock output.
// [RQ19] Address wraps at all ones; control 13:5 zero.
module mmd_indirect_register_access (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic mdc,
    input wire logic mdio_in,
    output logic mdio_out,
    output logic mdio_oe_n,
    input wire logic [4:0] phy_addr_strap,
    output logic clk_out_en
);
    import mmd_pkg::*;

    logic mdc_s1_r, mdc_s2_r, mdc_d_r, mdio_s1_r, mdio_s2_r;
    logic [4:0] strap_s1_r, strap_s2_r, phy_addr_r;
    logic [1:0] strap_cnt_r;
    frame_st_t st_r, st_nxt;
    logic [4:0] cnt_r, cnt_nxt;
    logic [11:0] hdr_r, hdr_nxt;
    logic [15:0] sh_r, sh_nxt;
    logic mdio_out_r, mdio_out_nxt, mdio_oe_n_r, mdio_oe_n_nxt;
    logic [15:0] ctrl_r, ctrl_nxt, addr_r, addr_nxt, ext_clk_r, ext_clk_nxt;
    logic clk_out_en_r;
    logic [15:0] regs_r [32];
    logic arr_we;
    logic [4:0] arr_idx;
    logic rise, bit_in, commit, is_rd, win_ok, win_hit, ext_direct;
    logic [4:0] reg_sel;
    logic [1:0] fn;
    logic [15:0] wr_word, ext_val, rd_val;

    // Pins pass two flops before use; MDC also feeds a third flop that the edge detect compares against.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mdc_s1_r <= 1'b0;
            mdc_s2_r <= 1'b0;
            mdc_d_r <= 1'b0;
            mdio_s1_r <= 1'b1;
            mdio_s2_r <= 1'b1;
            strap_s1_r <= PHY_ADDR_RESET;
            strap_s2_r <= PHY_ADDR_RESET;
        end else if (ce) begin
            mdc_s1_r <= mdc;
            mdc_s2_r <= mdc_s1_r;
            mdc_d_r <= mdc_s2_r;
            mdio_s1_r <= mdio_in;
            mdio_s2_r <= mdio_s1_r;
            strap_s1_r <= phy_addr_strap;
            strap_s2_r <= strap_s1_r;
        end
    end

    // The strap synchroniser starts from its reset value, so the strap is sampled
    // until the second stage has filled and only then frozen.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            phy_addr_r <= PHY_ADDR_RESET;
            strap_cnt_r <= 2'h0;
        end else if (ce && strap_cnt_r != STRAP_LAST) begin
            phy_addr_r <= strap_s2_r;
            strap_cnt_r <= strap_cnt_r + 2'h1;
        end
    end

    // Decoded view of the frame and of the control register.
    assign rise = mdc_s2_r & ~mdc_d_r;
    assign bit_in = mdio_s2_r;
    assign is_rd = (hdr_r[11:10] == OP_READ);
    assign reg_sel = hdr_r[4:0];
    assign fn = ctrl_r[15:14]; // RQ6
    assign win_ok = (ctrl_r[4:0] == DEVSEL_GENERAL); // RQ3 RQ4 RQ5
    assign win_hit = (reg_sel == REG_WIN) && win_ok;
    assign wr_word = {sh_r[14:0], bit_in};
    // Folded direct registers exclude the two window registers themselves.
    assign ext_direct = (addr_r < DIRECT_SPAN) && (addr_r[4:0] != REG_CTRL)
                        && (addr_r[4:0] != REG_WIN); // RQ2

    // Read value of the extended register that the address register selects.
    always_comb begin
        if (addr_r == CLK_CTRL_ADDR) begin
            ext_val = ext_clk_r; // RQ17
        end else if (ext_direct) begin
            ext_val = regs_r[addr_r[4:0]];
        end else begin
            ext_val = REG_RESET;
        end
    end

    // Read value for the direct register named by the frame.
    always_comb begin
        if (reg_sel == REG_CTRL) begin
            rd_val = ctrl_r;
        end else if (reg_sel == REG_WIN) begin
            if (!win_ok) begin
                rd_val = REG_RESET; // RQ5
            end else if (fn == FN_ADDR) begin
                rd_val = addr_r; // RQ7
            end else begin
                rd_val = ext_val; // RQ8 RQ16
            end
        end else begin
            rd_val = regs_r[reg_sel]; // RQ1
        end
    end

    // Frame receiver: sample on synchronised MDC rising edges, drive after them.
    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        hdr_nxt = hdr_r;
        sh_nxt = sh_r;
        mdio_out_nxt = mdio_out_r;
        mdio_oe_n_nxt = mdio_oe_n_r;
        commit = 1'b0;
        if (rise) begin
            case (st_r)
                ST_IDLE: begin
                    if (!bit_in) begin
                        st_nxt = ST_START;
                    end
                end
                ST_START: begin
                    cnt_nxt = 5'h00;
                    st_nxt = bit_in ? ST_HDR : ST_IDLE;
                end
                ST_HDR: begin
                    hdr_nxt = {hdr_r[10:0], bit_in};
                    cnt_nxt = cnt_r + 5'h01;
                    if (cnt_r == HDR_LAST) begin
                        cnt_nxt = 5'h00;
                        // Frames for another address still get counted out.
                        if (hdr_nxt[9:5] == phy_addr_r && (hdr_nxt[11:10] == OP_READ
                            || hdr_nxt[11:10] == OP_WRITE)) begin
                            st_nxt = ST_TA;
                        end else begin
                            st_nxt = ST_SKIP;
                        end
                    end
                end
                ST_TA: begin
                    cnt_nxt = cnt_r + 5'h01;
                    if (cnt_r == 5'h00) begin
                        if (is_rd) begin
                            mdio_out_nxt = 1'b0;
                            mdio_oe_n_nxt = 1'b0;
                            sh_nxt = rd_val;
                        end
                    end else begin
                        st_nxt = ST_DATA;
                        cnt_nxt = 5'h00;
                        if (is_rd) begin
                            mdio_out_nxt = sh_r[15];
                            sh_nxt = {sh_r[14:0], 1'b0};
                        end
                    end
                end
                ST_DATA: begin
                    cnt_nxt = cnt_r + 5'h01;
                    if (is_rd) begin
                        mdio_out_nxt = sh_r[15];
                        sh_nxt = {sh_r[14:0], 1'b0};
                    end else begin
                        sh_nxt = wr_word;
                    end
                    if (cnt_r == DATA_LAST) begin
                        commit = 1'b1;
                        mdio_out_nxt = 1'b1;
                        mdio_oe_n_nxt = 1'b1;
                        st_nxt = ST_IDLE;
                    end
                end
                ST_SKIP: begin
                    cnt_nxt = cnt_r + 5'h01;
                    if (cnt_r == SKIP_LAST) begin
                        st_nxt = ST_IDLE;
                    end
                end
                default: begin
                    st_nxt = ST_IDLE;
                end
            endcase
        end
    end

    // Register effects of a completed frame; side effects land after the data phase.
    always_comb begin
        ctrl_nxt = ctrl_r;
        addr_nxt = addr_r; // RQ13
        ext_clk_nxt = ext_clk_r;
        arr_we = 1'b0;
        arr_idx = reg_sel;
        if (commit && !is_rd) begin
            if (reg_sel == REG_CTRL) begin
                ctrl_nxt = {wr_word[15:14], 9'h000, wr_word[4:0]}; // RQ3 RQ6 RQ19
            end else if (reg_sel == REG_WIN) begin
                if (win_ok && fn == FN_ADDR) begin
                    addr_nxt = wr_word; // RQ7 RQ15
                end else if (win_ok && addr_r == CLK_CTRL_ADDR) begin
                    ext_clk_nxt = wr_word; // RQ18
                end else if (win_ok && ext_direct) begin
                    arr_we = 1'b1;
                    arr_idx = addr_r[4:0];
                end
            end else begin
                arr_we = 1'b1; // RQ1
            end
        end
        // Post increment; the sixteen bit sum wraps to zero past all ones.
        if (commit && win_hit && (fn == FN_INC_RW || (fn == FN_INC_WR && !is_rd))) begin
            addr_nxt = addr_r + 16'h0001; // RQ9 RQ10 RQ19
        end
    end

    // State registers of the frame receiver and the window registers.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r <= ST_IDLE;
            cnt_r <= 5'h00;
            hdr_r <= 12'h000;
            sh_r <= REG_RESET;
            mdio_out_r <= 1'b1;
            mdio_oe_n_r <= 1'b1;
            ctrl_r <= REG_RESET;
            addr_r <= REG_RESET;
            ext_clk_r <= CLK_CTRL_RESET;
            clk_out_en_r <= 1'b1;
        end else if (ce) begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            hdr_r <= hdr_nxt;
            sh_r <= sh_nxt;
            mdio_out_r <= mdio_out_nxt;
            mdio_oe_n_r <= mdio_oe_n_nxt;
            ctrl_r <= ctrl_nxt;
            addr_r <= addr_nxt;
            ext_clk_r <= ext_clk_nxt;
            clk_out_en_r <= ~ext_clk_r[CLK_OFF_BIT]; // RQ18
        end
    end

    // Plain direct registers; the window offsets exist here but are never selected.
    for (genvar g = 0; g < 32; g++) begin : gen_regs
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                regs_r[g] <= REG_RESET;
            end else if (ce && arr_we && arr_idx == 5'(g)) begin
                regs_r[g] <= wr_word; // RQ1
            end
        end
    end

    assign mdio_out = mdio_out_r;
    assign mdio_oe_n = mdio_oe_n_r;
    assign clk_out_en = clk_out_en_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    ctrl_reserved_zero_a: assert property (ctrl_r[13:5] == 9'h000) // RQ19
        else $error("control reserved bits not zero");
    ctrl_write_fields_a: assert property (commit && !is_rd && reg_sel == REG_CTRL |=> // RQ3
        ctrl_r[15:14] == $past(wr_word[15:14]) && ctrl_r[4:0] == $past(wr_word[4:0]))
        else $error("control write not stored");
    bad_select_ignored_a: assert property (commit && reg_sel == REG_WIN && !win_ok |=> // RQ5
        $stable(addr_r) && $stable(ext_clk_r))
        else $error("window access with wrong select had effect");
    addr_fn_write_a: assert property (commit && !is_rd && win_hit && fn == FN_ADDR |=> // RQ7
        addr_r == $past(wr_word))
        else $error("address function write not stored");
    data_no_inc_a: assert property (commit && win_hit && fn == FN_DATA |=> // RQ8
        $stable(addr_r))
        else $error("address moved without increment function");
    inc_rw_step_a: assert property (commit && win_hit && fn == FN_INC_RW |=> // RQ9
        addr_r == $past(addr_r) + 16'h0001)
        else $error("read-write increment missing");
    inc_wr_only_a: assert property (commit && win_hit && fn == FN_INC_WR |=> // RQ10
        addr_r == (is_rd ? $past(addr_r) : $past(addr_r) + 16'h0001))
        else $error("write-only increment wrong");
    indirect_no_ctrl_a: assert property (commit && win_hit && fn != FN_ADDR // RQ2
        && addr_r[4:0] == REG_CTRL |=> $stable(ctrl_r))
        else $error("indirect access reached control");
    clk_out_follow_a: assert property (ext_clk_r[CLK_OFF_BIT] ##1 ext_clk_r[CLK_OFF_BIT] // RQ18
        && ce |=> !clk_out_en_r)
        else $error("clock output not disabled");
    read_drive_a: assert property (rise && st_r == ST_TA && cnt_r == 5'h00 && is_rd // RQ1
        && ce |=> !mdio_oe_n_r && !mdio_out_r)
        else $error("turnaround zero not driven");
endmodule

/* dv/mdio_station.sv */
// Station management controller model that frames read and write accesses.
`timescale 1ns/1ps
module mdio_station
    import mmd_pkg::*;
#(
    parameter logic [4:0] PHY = 5'h05
) (
    input wire logic clk,
    input wire logic mdio_out,
    input wire logic mdio_oe_n,
    output logic mdc,
    output logic mdio_in
);
    logic drv_en;
    logic drv_bit;

    // The line has a pull-up, so a released wire reads high.
    assign mdio_in = !mdio_oe_n ? mdio_out : (drv_en ? drv_bit : 1'b1);

    // Clock parked low and line released until the first frame.
    initial begin
        mdc = 1'b0;
        drv_en = 1'b0;
        drv_bit = 1'b1;
    end

    // One bit time: a half period of 8 clocks covers the block's synchroniser lag.
    task automatic bit_slot(input logic en, input logic b, output logic seen);
        mdc <= 1'b0;
        drv_en <= en;
        drv_bit <= b;
        repeat (8) @(posedge clk);
        seen = mdio_in;
        mdc <= 1'b1;
        repeat (8) @(posedge clk);
    endtask

    // Two idle ones, then the frame; turnaround and data are released on reads.
    task automatic frame(input logic [1:0] op, input logic [4:0] ra,
                         input logic [15:0] wd, output logic [15:0] rd);
        logic [33:0] bits;
        logic s;
        bits = {4'b1101, op, PHY, ra, 2'b10, wd};
        for (int i = 33; i >= 0; i--) begin
            bit_slot(!(op == OP_READ && i < 18), bits[i], s);
            if (i < 16) rd[i] = s;
        end
        drv_en <= 1'b0;
        @(posedge clk);
    endtask
endmodule

/* dv/tb_mmd_indirect_register_access.sv */
// Self-checking bench for the indirect extended register access block.
`timescale 1ns/1ps
module tb_mmd_indirect_register_access;
    import mmd_pkg::*;
    localparam logic [4:0] PHY = 5'h05;
    localparam int LIMIT = 80000;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic mdc;
    logic mdio_in;
    logic mdio_out;
    logic mdio_oe_n;
    logic clk_out_en;
    logic [31:0] seed = 32'h36;
    int miscompares = 0;
    int compares = 0;
    int cycles = 0;

    mmd_indirect_register_access DUT (.clk(clk), .rst(rst), .ce(1'b1), .mdc(mdc),
        .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n),
        .phy_addr_strap(PHY), .clk_out_en(clk_out_en));
    mdio_station #(.PHY(PHY)) u_sta (.clk(clk), .mdio_out(mdio_out),
        .mdio_oe_n(mdio_oe_n), .mdc(mdc), .mdio_in(mdio_in));

    always #5 clk = ~clk;

    // A hung frame must not stall the run forever.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            miscompares++;
            end_of_test();
        end
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction

    // Control keeps only the function and select fields.
    function automatic logic [15:0] ctrl_view(input logic [15:0] v);
        return {v[15:14], 9'h000, v[4:0]};
    endfunction

    function automatic logic [15:0] next_addr(input logic [15:0] a, input logic [1:0] f,
                                              input logic w);
        return (f == FN_INC_RW || (f == FN_INC_WR && w)) ? a + 16'h0001 : a;
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test;
        if (miscompares == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [4:0] ra, input logic [15:0] d);
        logic [15:0] junk;
        u_sta.frame(OP_WRITE, ra, d, junk);
    endtask

    task automatic rd(input logic [4:0] ra, input logic [15:0] exp);
        logic [15:0] got;
        u_sta.frame(OP_READ, ra, 16'h0000, got);
        check(got, exp);
    endtask

    // Address is always loaded before any data function is used.
    task automatic setaddr(input logic [15:0] a);
        wr(REG_CTRL, 16'h001F);
        wr(REG_WIN, a);
    endtask

    // Main sequence; the burst loop covers both increment functions.
    initial begin
        logic [15:0] a;
        logic [15:0] mem [0:2];
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (10) @(posedge clk);
        check({15'h0000, clk_out_en}, 16'h0001);
        rd(REG_CTRL, 16'h0000);
        setaddr(CLK_CTRL_ADDR);
        wr(REG_CTRL, 16'h401F);
        rd(REG_WIN, CLK_CTRL_RESET);
        wr(REG_WIN, 16'h0C50);
        repeat (4) @(posedge clk);
        check({15'h0000, clk_out_en}, 16'h0000);
        rd(REG_WIN, 16'h0C50);
        rd(REG_WIN, 16'h0C50);
        wr(REG_WIN, CLK_CTRL_RESET);
        repeat (4) @(posedge clk);
        check({15'h0000, clk_out_en}, 16'h0001);
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            a = {11'h000, seed[20:16]};
            if (a[4:0] == REG_CTRL || a[4:0] == REG_WIN) a[4:0] = 5'h1F;
            wr(a[4:0], seed[15:0]);
            rd(a[4:0], seed[15:0]);
        end
        seed = xs(seed);
        wr(REG_CTRL, seed[15:0]);
        rd(REG_CTRL, ctrl_view(seed[15:0]));
        seed = xs(seed);
        setaddr(seed[15:0]);
        wr(REG_WIN, 16'h0002);
        rd(REG_WIN, 16'h0002);
        wr(REG_CTRL, 16'h401F);
        seed = xs(seed);
        wr(REG_WIN, seed[15:0]);
        rd(5'h02, seed[15:0]);
        wr(REG_CTRL, 16'h001F);
        rd(REG_WIN, 16'h0002);
        for (int f = 2; f < 4; f++) begin
            wr(5'h07, 16'hA5A5);
            wr(5'h08, 16'h5A5A);
            setaddr(16'h0004);
            wr(REG_CTRL, {f[1:0], 14'h001F});
            a = 16'h0004;
            for (int k = 0; k < 3; k++) begin
                seed = xs(seed);
                mem[k] = seed[15:0];
                wr(REG_WIN, mem[k]);
                a = next_addr(a, f[1:0], 1'b1);
            end
            for (int k = 0; k < 3; k++) rd(5'h04 + 5'(k), mem[k]);
            rd(REG_WIN, 16'hA5A5);
            a = next_addr(a, f[1:0], 1'b0);
            rd(REG_WIN, (a == 16'h0007) ? 16'hA5A5 : 16'h5A5A);
            a = next_addr(a, f[1:0], 1'b0);
            wr(REG_CTRL, 16'h001F);
            rd(REG_WIN, a);
        end
        wr(REG_CTRL, 16'h401E);
        seed = xs(seed);
        wr(REG_WIN, seed[15:0]);
        rd(REG_WIN, 16'h0000);
        rd(REG_CTRL, 16'h401E);
        wr(REG_CTRL, 16'h001F);
        rd(REG_WIN, a);
        setaddr({11'h000, REG_CTRL});
        wr(REG_CTRL, 16'h401F);
        wr(REG_WIN, 16'h0000);
        rd(REG_CTRL, 16'h401F);
        rd(REG_WIN, 16'h0000);
        setaddr(16'hFFFF);
        wr(REG_CTRL, 16'h801F);
        rd(REG_WIN, 16'h0000);
        wr(REG_CTRL, 16'h001F);
        rd(REG_WIN, 16'h0000);
        end_of_test();
    end
endmodule
